// File: rtl/supervisor_consts.svh
// constants for the protected-mode supervisor: address windows, overlay pages, sizes
// assumes inclusion by the package, the supervisor modules and their assertions only
`ifndef SUPERVISOR_CONSTS_SVH
`define SUPERVISOR_CONSTS_SVH
`define PADDR_W          14
`define OVL_W            4
`define DADDR_W          14
`define PROT_PLO         14'h2001
`define PROT_PHI         14'h3fff
`define GATE_ADDR        14'h2000
`define PROT_POVL_LO     4'hc
`define PROT_POVL_HI     4'hf
`define GATE_OVL         4'hf
`define PROT_DLO         14'h0000
`define PROT_DHI         14'h17ff
`define PROT_DOVL        4'hf
`define PAGE_SHIFT       10
`define PAGE_CNT         16
`define PAGE_IDX_W       4
`define ERASE_CYCLES     5'h10
`define ERASE_CNT_W      5
`define MAX_NEST         2'h1
`endif

// File: rtl/supervisor_pkg.sv
// types shared by the supervisor, its assertions, the core model and the bench
// assumes supervisor_consts.svh is in the include path
`include "supervisor_consts.svh"
package supervisor_pkg;
	typedef enum logic [1:0] {
		FLOW_SEQ,
		FLOW_JUMP,
		FLOW_CALL,
		FLOW_RTI
	} flow_t;

	typedef struct packed {
		logic                   valid;
		logic [`PADDR_W-1:0]    addr;
		logic [`OVL_W-1:0]      ovl;
		flow_t                  flow;
	} fetch_t;

	typedef struct packed {
		logic                   valid;
		logic [`DADDR_W-1:0]    addr;
		logic [`OVL_W-1:0]      ovl;
	} data_t;

	typedef struct packed {
		logic [`OVL_W-1:0]      ovl;
		logic [`PADDR_W-1:0]    addr;
	} resume_t;

	typedef enum logic [1:0] {
		MODE_USER,
		MODE_PRIV,
		MODE_ERASE
	} mode_t;
endpackage

// File: rtl/claim_map.sv
// protection claim map: one bit per 1K page of internal program and data ram
// assumes single clock, async active-high reset; read data registered
`timescale 1ns/100ps
`include "supervisor_consts.svh"
module claim_map (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     clear,
	input  wire logic                     wr_en,
	input  wire logic                     wr_is_data,
	input  wire logic [`PAGE_IDX_W-1:0]   wr_page,
	input  wire logic                     wr_claim,
	input  wire logic [`PAGE_IDX_W-1:0]   rd_ppage,
	input  wire logic [`PAGE_IDX_W-1:0]   rd_dpage,
	output logic                          rd_pclaim,
	output logic                          rd_dclaim
);
	logic [`PAGE_CNT-1:0] pmap_q;
	logic [`PAGE_CNT-1:0] dmap_q;

	genvar g;
	generate
		for (g = 0; g < `PAGE_CNT; g = g + 1) begin : g_page
			wire hit = wr_en && (wr_page == `PAGE_IDX_W'(g));
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					pmap_q[g] <= 1'b0;
					dmap_q[g] <= 1'b0;
				end else if (clear) begin
					pmap_q[g] <= 1'b0;
					dmap_q[g] <= 1'b0;
				end else if (hit) begin
					if (wr_is_data) begin
						dmap_q[g] <= wr_claim;
					end else begin
						pmap_q[g] <= wr_claim;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_pclaim <= 1'b0;
			rd_dclaim <= 1'b0;
		end else begin
			rd_pclaim <= pmap_q[rd_ppage];
			rd_dclaim <= dmap_q[rd_dpage];
		end
	end
endmodule

// File: rtl/secure_mode_supervisor.sv
// protected-mode supervisor: gate entry, exit on branch, violation reset, nesting
// assumes core fetch/data strobes on SYS_CLK, one cycle per instruction
`timescale 1ns/100ps
`include "supervisor_consts.svh"
// How it works
// - user-mode access to program 2001-3fff or program overlay c-f starts an erasing reset.
// - user-mode access to data 0000-17ff or data overlay f starts an erasing reset.
// - privileged mode is entered only by call, jump or step to 2000 with overlay f.
// - a privileged branch into unprotected program space returns to user mode from the outer level; a nested level drops one level.
// - emulator bus requests are synchronized in every mode but granted only in user mode.
// - interrupts are held off while protected code flags a sensitive move.
// - privileged mode nests at most one level, from an interrupt handler.
// - an interrupt vector into user space while nested starts an erasing reset.
// - return from interrupt of privileged code must hit the saved address and overlay.
// - privileged code claims 1K pages of program and data ram, shielded from user mode.
// - register erase is signalled whenever the supervisor causes or handles a reset.
// - interrupt enable and mask state are readable on a read-only port.
// - the 16K word privileged rom is mapped into program space and selected here.
// - the 4K scratch ram is selected only for privileged accesses.
module secure_mode_supervisor (
	input  wire logic                      SYS_CLK,
	input  wire logic                      RST,
	input  wire supervisor_pkg::fetch_t    FETCH,
	input  wire supervisor_pkg::data_t     DATA,
	input  wire logic                      IRQ_TAKEN,
	input  wire logic                      IRQ_VEC_USER,
	input  wire logic                      IRQ_PENDING,
	input  wire logic                      SENSITIVE_MOVE,
	input  wire logic                      EMU_BUS_REQ,
	input  wire logic                      CLAIM_WR,
	input  wire logic                      CLAIM_IS_DATA,
	input  wire logic [`PAGE_IDX_W-1:0]    CLAIM_PAGE,
	input  wire logic                      CLAIM_SET,
	input  wire logic                      INT_ENABLE,
	input  wire logic [11:0]               INT_MASK,
	output logic                           PRIV_MODE,
	output logic                           VIOLATION_RESET,
	output logic                           ERASE_REGS,
	output logic                           EMU_BUS_GRANT,
	output logic                           IRQ_ALLOW,
	output logic                           ROM_SEL,
	output logic                           SCRATCH_SEL,
	output logic [12:0]                    INT_STATE,
	output logic [1:0]                     NEST_DEPTH
);
	supervisor_pkg::mode_t    mode_q, mode_d;
	logic [1:0]               nest_q, nest_d;
	supervisor_pkg::resume_t  save_q [0:1];
	logic [1:0]               isr_q, isr_d;
	logic [`ERASE_CNT_W-1:0]  erase_cnt_q;
	logic                     emu_s1_q, emu_s2_q;

	wire priv = (mode_q == supervisor_pkg::MODE_PRIV);
	wire user = (mode_q == supervisor_pkg::MODE_USER);

	// program space decode from 2000 for the exit check; the user check decodes from 2001
	function automatic logic prot_prog(input logic [`PADDR_W-1:0] a,
		input logic [`OVL_W-1:0] o);
		prot_prog = (a >= `GATE_ADDR && a <= `PROT_PHI) ||
			(o >= `PROT_POVL_LO && o <= `PROT_POVL_HI);
	endfunction

	wire at_gate    = FETCH.valid && FETCH.addr == `GATE_ADDR && FETCH.ovl == `GATE_OVL &&
		FETCH.flow != supervisor_pkg::FLOW_RTI;
	wire fetch_prot = prot_prog(FETCH.addr, FETCH.ovl);
	wire fetch_bad  = FETCH.valid && ((FETCH.addr >= `PROT_PLO && FETCH.addr <= `PROT_PHI) ||
		(FETCH.ovl >= `PROT_POVL_LO && FETCH.ovl <= `PROT_POVL_HI));
	wire data_bad   = DATA.valid && ((DATA.addr <= `PROT_DHI) || (DATA.ovl == `PROT_DOVL));
	wire p_page_bad;
	wire d_page_bad;
	logic fetch_v_q, data_v_q;

	claim_map u_claim (
		.clk        (SYS_CLK),
		.rst        (RST),
		.clear      (mode_q == supervisor_pkg::MODE_ERASE),
		.wr_en      (CLAIM_WR && priv),
		.wr_is_data (CLAIM_IS_DATA),
		.wr_page    (CLAIM_PAGE),
		.wr_claim   (CLAIM_SET),
		.rd_ppage   (FETCH.addr[`PADDR_W-1:`PAGE_SHIFT]),
		.rd_dpage   (DATA.addr[`DADDR_W-1:`PAGE_SHIFT]),
		.rd_pclaim  (p_page_bad),
		.rd_dclaim  (d_page_bad)
	);

	// claim lookup is registered, so claimed pages trip one cycle late
	wire claim_bad  = user && ((fetch_v_q && p_page_bad) || (data_v_q && d_page_bad));
	wire is_branch  = FETCH.valid && (FETCH.flow == supervisor_pkg::FLOW_JUMP ||
		FETCH.flow == supervisor_pkg::FLOW_CALL);
	wire rti        = FETCH.valid && FETCH.flow == supervisor_pkg::FLOW_RTI;
	wire rti_priv   = rti && isr_q != 2'h0;
	wire top_lvl    = (isr_q == 2'h2);
	wire rti_ok     = FETCH.addr == save_q[top_lvl].addr &&
		FETCH.ovl == save_q[top_lvl].ovl;
	wire enter      = user && at_gate;
	wire nest_enter = priv && at_gate && isr_q != 2'h0 && nest_q == `MAX_NEST;
	wire nest_over  = priv && at_gate && isr_q != 2'h0 && nest_q > `MAX_NEST;
	wire user_hit   = user && !at_gate && (fetch_bad || data_bad);
	wire vec_bad    = priv && IRQ_TAKEN && IRQ_VEC_USER && nest_q > `MAX_NEST;
	wire ret_bad    = rti_priv && !rti_ok;
	wire violation  = user_hit || claim_bad || vec_bad || ret_bad || nest_over;
	wire leave      = priv && is_branch && !fetch_prot && !(IRQ_TAKEN);

	always_comb begin
		mode_d = mode_q;
		nest_d = nest_q;
		isr_d  = isr_q;
		case (mode_q)
			supervisor_pkg::MODE_USER: begin
				if (violation) begin
					mode_d = supervisor_pkg::MODE_ERASE;
				end else if (enter) begin
					mode_d = supervisor_pkg::MODE_PRIV;
					nest_d = 2'h1;
				end
			end
			supervisor_pkg::MODE_PRIV: begin
				if (violation) begin
					// depth drops at once so no nested level outlives the erase
					mode_d = supervisor_pkg::MODE_ERASE;
					nest_d = 2'h0;
					isr_d  = 2'h0;
				end else if (IRQ_TAKEN) begin
					isr_d = isr_q + 2'h1;
				end else if (nest_enter) begin
					nest_d = nest_q + 2'h1;
				end else if (rti_priv) begin
					isr_d  = isr_q - 2'h1;
					nest_d = (isr_q == 2'h2) ? nest_q : nest_q;
				end else if (leave) begin
					if (nest_q > 2'h1) begin
						nest_d = nest_q - 2'h1;
					end else begin
						mode_d = supervisor_pkg::MODE_USER;
						nest_d = 2'h0;
						isr_d  = 2'h0;
					end
				end
			end
			default: begin
				if (erase_cnt_q == `ERASE_CYCLES) begin
					mode_d = supervisor_pkg::MODE_USER;
					nest_d = 2'h0;
					isr_d  = 2'h0;
				end
			end
		endcase
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			mode_q <= supervisor_pkg::MODE_ERASE;
		end else begin
			mode_q <= mode_d;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			nest_q <= 2'h0;
		end else begin
			nest_q <= nest_d;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			isr_q <= 2'h0;
		end else begin
			isr_q <= isr_d;
		end
	end

	// resume point of each interrupted privileged level
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			save_q[0] <= '0;
			save_q[1] <= '0;
		end else if (mode_q == supervisor_pkg::MODE_ERASE) begin
			save_q[0] <= '0;
			save_q[1] <= '0;
		end else if (priv && IRQ_TAKEN && isr_q < 2'h2) begin
			save_q[isr_q[0]] <= {FETCH.ovl, FETCH.addr};
		end
	end

	// erase lasts a fixed window so the core sees a clean reset pulse
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			erase_cnt_q <= '0;
		end else if (mode_q == supervisor_pkg::MODE_ERASE) begin
			erase_cnt_q <= erase_cnt_q + `ERASE_CNT_W'(1);
		end else begin
			erase_cnt_q <= '0;
		end
	end

	// emulator request is asynchronous to the core
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			emu_s1_q <= 1'b0;
			emu_s2_q <= 1'b0;
		end else begin
			emu_s1_q <= EMU_BUS_REQ;
			emu_s2_q <= emu_s1_q;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			fetch_v_q <= 1'b0;
		end else begin
			fetch_v_q <= FETCH.valid;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			data_v_q <= 1'b0;
		end else begin
			data_v_q <= DATA.valid;
		end
	end

	wire erase_next  = (mode_d == supervisor_pkg::MODE_ERASE);
	wire priv_next   = (mode_d == supervisor_pkg::MODE_PRIV);
	// grant follows the next mode, so it never shares the first privileged cycle
	wire grant_ok    = emu_s2_q && (mode_d == supervisor_pkg::MODE_USER);
	wire irq_ok      = !erase_next && !(priv && SENSITIVE_MOVE);
	wire rom_hit     = FETCH.valid && FETCH.ovl == `GATE_OVL && !user_hit;
	wire scratch_hit = DATA.valid && priv && DATA.ovl == `PROT_DOVL;

	// one short register per output keeps each reset value beside its source
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			PRIV_MODE <= 1'b0;
		end else begin
			PRIV_MODE <= priv_next;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			VIOLATION_RESET <= 1'b1;
		end else begin
			VIOLATION_RESET <= erase_next;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ERASE_REGS <= 1'b1;
		end else begin
			ERASE_REGS <= erase_next;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			EMU_BUS_GRANT <= 1'b0;
		end else begin
			EMU_BUS_GRANT <= grant_ok;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			IRQ_ALLOW <= 1'b0;
		end else begin
			IRQ_ALLOW <= irq_ok;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ROM_SEL <= 1'b0;
		end else begin
			ROM_SEL <= rom_hit;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			SCRATCH_SEL <= 1'b0;
		end else begin
			SCRATCH_SEL <= scratch_hit;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			INT_STATE <= '0;
		end else begin
			INT_STATE <= {INT_ENABLE, INT_MASK};
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			NEST_DEPTH <= 2'h0;
		end else begin
			NEST_DEPTH <= nest_d;
		end
	end
endmodule

// File: verif/supervisor_props.sv
// port assertions for the protected-mode supervisor
// assumes a bind onto secure_mode_supervisor, one clock, RST async high
`timescale 1ns/100ps
`include "supervisor_consts.svh"
module supervisor_props (
	input wire logic                   SYS_CLK,
	input wire logic                   RST,
	input wire supervisor_pkg::fetch_t FETCH,
	input wire supervisor_pkg::data_t  DATA,
	input wire logic                   IRQ_TAKEN,
	input wire logic                   IRQ_VEC_USER,
	input wire logic                   SENSITIVE_MOVE,
	input wire logic                   INT_ENABLE,
	input wire logic [11:0]            INT_MASK,
	input wire logic                   PRIV_MODE,
	input wire logic                   VIOLATION_RESET,
	input wire logic                   ERASE_REGS,
	input wire logic                   EMU_BUS_GRANT,
	input wire logic                   IRQ_ALLOW,
	input wire logic [12:0]            INT_STATE,
	input wire logic [1:0]             NEST_DEPTH
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	wire usr   = !PRIV_MODE && !VIOLATION_RESET;
	wire gate  = FETCH.valid && FETCH.addr == `GATE_ADDR && FETCH.ovl == `GATE_OVL
		&& FETCH.flow != supervisor_pkg::FLOW_RTI;
	// a return from interrupt into the kernel is a legal resume, judged elsewhere
	wire pprot = FETCH.valid && FETCH.addr != `GATE_ADDR && FETCH.flow != supervisor_pkg::FLOW_RTI
		&& (FETCH.addr >= `PROT_PLO || FETCH.ovl >= `PROT_POVL_LO);
	wire dprot = DATA.valid && (DATA.addr <= `PROT_DHI || DATA.ovl == `PROT_DOVL);
	wire pout  = FETCH.valid && FETCH.flow inside {supervisor_pkg::FLOW_JUMP, supervisor_pkg::FLOW_CALL}
		&& FETCH.addr < `GATE_ADDR && FETCH.ovl < `PROT_POVL_LO;
	sequence erase_half;
		(VIOLATION_RESET && ERASE_REGS) [*8];
	endsequence
	chk_prog_guard: assert property (usr && pprot |=> VIOLATION_RESET)
		else $error("user program access not reset");
	chk_data_guard: assert property (usr && dprot |=> VIOLATION_RESET)
		else $error("user data access not reset");
	chk_gate_only: assert property ($rose(PRIV_MODE) |-> $past(gate) && $past(usr))
		else $error("privileged mode entered off the gate");
	chk_branch_exit: assert property (PRIV_MODE && NEST_DEPTH == 2'h1 && pout
		&& !IRQ_TAKEN |=> !PRIV_MODE) else $error("branch out did not leave privileged mode");
	chk_emu_quiet: assert property (PRIV_MODE |-> !EMU_BUS_GRANT)
		else $error("emulator granted in privileged mode");
	chk_irq_hold: assert property (PRIV_MODE && SENSITIVE_MOVE |=> !IRQ_ALLOW)
		else $error("interrupt allowed during sensitive move");
	chk_nest_limit: assert property (NEST_DEPTH == 2'h2 && gate && !VIOLATION_RESET
		|=> VIOLATION_RESET) else $error("third privileged level not reset");
	chk_nest_vector: assert property (NEST_DEPTH == 2'h2 && IRQ_TAKEN && IRQ_VEC_USER
		|=> VIOLATION_RESET) else $error("user vector while nested not reset");
	chk_erase_len: assert property ($rose(VIOLATION_RESET) |-> erase_half ##1 erase_half
		##1 VIOLATION_RESET ##1 !VIOLATION_RESET) else $error("erase window length wrong");
	chk_int_mirror: assert property (!$past(RST) |->
		INT_STATE == {$past(INT_ENABLE), $past(INT_MASK)}) else $error("interrupt state wrong");
	chk_reset_user: assert property ($fell(VIOLATION_RESET) |->
		!PRIV_MODE && NEST_DEPTH == 2'h0) else $error("not user mode after reset");
endmodule

// File: verif/core_model.sv
// core side model: presents the sequencer's fetch and data requests
// assumes the supervisor's chip reset holds the core still
`timescale 1ns/100ps
module core_model (
	input  wire logic                   hold,
	input  wire supervisor_pkg::fetch_t cmd,
	input  wire supervisor_pkg::data_t  dcmd,
	output supervisor_pkg::fetch_t      fetch,
	output supervisor_pkg::data_t       data
);
	// a core in reset issues nothing; its address lines float, shown inverted
	assign fetch = hold ? '{1'b0, ~cmd.addr, cmd.ovl, cmd.flow} : cmd;
	assign data  = hold ? '{1'b0, ~dcmd.addr, dcmd.ovl} : dcmd;
endmodule

// File: verif/testbench.sv
// self-checking bench for the protected-mode supervisor
// assumes core_model stands between bench requests and the supervisor
`timescale 1ns/100ps
module testbench;
	logic sys_clk = 0, rst = 1, irq_t = 0, irq_u = 0, sens = 0, emu = 0;
	logic cl_wr = 0, cl_set = 0, cl_dat = 1, int_en = 0, vr, er, pm, gnt, allow, rom, scr;
	logic [3:0] cl_pg = 4'h0;
	logic [11:0] int_mask = 12'h000;
	logic [12:0] int_st;
	logic [1:0] depth;
	supervisor_pkg::fetch_t cmd = '0, fetch;
	supervisor_pkg::data_t dcmd = '0, data;
	int err_count = 0, checked = 0, i;
	logic [13:0] ta [6] = '{14'h2001, 14'h3fff, 14'h0100, 14'h0000, 14'h17ff, 14'h0100};
	logic [3:0]  to [6] = '{4'h0, 4'h0, 4'hc, 4'h0, 4'h0, 4'hf};
	always #12.5 sys_clk = ~sys_clk;
	core_model CORE (.hold(vr), .cmd(cmd), .dcmd(dcmd), .fetch(fetch), .data(data));
	secure_mode_supervisor DUT (.SYS_CLK(sys_clk), .RST(rst), .FETCH(fetch), .DATA(data),
		.IRQ_TAKEN(irq_t), .IRQ_VEC_USER(irq_u), .IRQ_PENDING(1'b0), .SENSITIVE_MOVE(sens),
		.EMU_BUS_REQ(emu), .CLAIM_WR(cl_wr), .CLAIM_IS_DATA(cl_dat), .CLAIM_PAGE(cl_pg),
		.CLAIM_SET(cl_set), .INT_ENABLE(int_en), .INT_MASK(int_mask), .PRIV_MODE(pm),
		.VIOLATION_RESET(vr), .ERASE_REGS(er), .EMU_BUS_GRANT(gnt), .IRQ_ALLOW(allow),
		.ROM_SEL(rom), .SCRATCH_SEL(scr), .INT_STATE(int_st), .NEST_DEPTH(depth));
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task idle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task step(input supervisor_pkg::flow_t f, input logic [13:0] a, input logic [3:0] o);
		@(posedge sys_clk) cmd <= '{1'b1, a, o, f};
		@(posedge sys_clk) cmd.valid <= 1'b0;
		#1;
	endtask
	task dacc(input logic [13:0] a, input logic [3:0] o);
		@(posedge sys_clk) dcmd <= '{1'b1, a, o};
		@(posedge sys_clk) dcmd.valid <= 1'b0;
		#1;
	endtask
	task irq(input logic [13:0] a, input logic [3:0] o);
		@(posedge sys_clk) cmd <= '{1'b1, a, o, supervisor_pkg::FLOW_SEQ};
		irq_t <= 1'b1;
		irq_u <= 1'b1;
		@(posedge sys_clk) cmd.valid <= 1'b0;
		irq_t <= 1'b0;
		#1;
	endtask
	task enter;
		step(supervisor_pkg::FLOW_CALL, 14'h2000, 4'hf);
	endtask
	task leave;
		step(supervisor_pkg::FLOW_JUMP, 14'h0100, 4'h0);
	endtask
	task clear;
		for (i = 0; i < 40 && vr !== 1'b0; i++) @(posedge sys_clk);
		#1;
		chk("erase_end", 16'h0, {15'h0, vr});
		chk("user_after", 16'h0, {13'h0, pm, depth});
	endtask
	task viol;
		idle(1);
		chk("violation", 16'h3, {14'h0, vr, er});
		clear;
	endtask
	task t_start;
		clear;
		@(posedge sys_clk) int_en <= 1'b1;
		int_mask <= 12'ha5c;
		idle(2);
		chk("int_state", 16'h1a5c, {3'h0, int_st});
	endtask
	task t_gate;
		step(supervisor_pkg::FLOW_SEQ, 14'h2000, 4'h0);
		chk("no_gate", 16'h0, {15'h0, pm});
		for (int f = 0; f < 3; f++) begin
			step(supervisor_pkg::flow_t'(f), 14'h2000, 4'hf);
			chk("entered", 16'h5, {13'h0, pm, depth});
			chk("rom_sel", 16'h1, {15'h0, rom});
			leave;
			chk("left", 16'h0, {15'h0, pm});
		end
	endtask
	task t_guard;
		for (int k = 0; k < 6; k++) begin
			if (k < 3) step(supervisor_pkg::FLOW_SEQ, ta[k], to[k]);
			else dacc(ta[k], to[k]);
			chk("scratch_user", 16'h0, {15'h0, scr});
			viol;
		end
		dacc(14'h1800, 4'he);
		step(supervisor_pkg::FLOW_SEQ, 14'h1fff, 4'hb);
		idle(1);
		chk("edge_ok", 16'h0, {15'h0, vr});
	endtask
	task t_nest;
		enter;
		irq(14'h2100, 4'hf);
		enter;
		chk("nested", 16'h2, {14'h0, depth});
		irq(14'h2050, 4'hf);
		viol;
	endtask
	task t_return;
		enter;
		irq(14'h2100, 4'hf);
		step(supervisor_pkg::FLOW_RTI, 14'h2100, 4'hf);
		chk("resumed", 16'h1, {15'h0, pm});
		irq(14'h2100, 4'hf);
		step(supervisor_pkg::FLOW_RTI, 14'h2101, 4'hf);
		viol;
	endtask
	task t_emu_move;
		@(posedge sys_clk) emu <= 1'b1;
		idle(4);
		chk("grant_user", 16'h1, {15'h0, gnt});
		enter;
		chk("grant_gate", 16'h0, {15'h0, gnt});
		@(posedge sys_clk) sens <= 1'b1;
		idle(3);
		chk("grant_priv", 16'h0, {15'h0, gnt});
		chk("irq_held", 16'h0, {15'h0, allow});
		dacc(14'h0200, 4'hf);
		chk("scratch", 16'h1, {15'h0, scr});
		@(posedge sys_clk) sens <= 1'b0;
		emu <= 1'b0;
		leave;
	endtask
	task t_claim;
		// a user-mode claim must be refused, so page 7 stays open
		@(posedge sys_clk) {cl_wr, cl_set, cl_pg} <= {2'h3, 4'h7};
		@(posedge sys_clk) cl_wr <= 1'b0;
		dacc(14'h1c00, 4'h0);
		idle(1);
		chk("refused", 16'h0, {15'h0, vr});
		enter;
		@(posedge sys_clk) {cl_wr, cl_set, cl_pg} <= {2'h3, 4'h6};
		@(posedge sys_clk) cl_wr <= 1'b0;
		leave;
		dacc(14'h1800, 4'h0);
		viol;
		// program pages are claimed through the same port
		enter;
		@(posedge sys_clk) {cl_wr, cl_set, cl_dat, cl_pg} <= {3'h6, 4'h5};
		@(posedge sys_clk) cl_wr <= 1'b0;
		leave;
		step(supervisor_pkg::FLOW_SEQ, 14'h1400, 4'h0);
		viol;
	endtask
	task conclude;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		t_start;
		t_gate;
		t_guard;
		t_nest;
		t_return;
		t_emu_move;
		t_claim;
		conclude;
	end
	initial begin
		#100000;
		err_count++;
		conclude;
	end
endmodule
bind secure_mode_supervisor supervisor_props PROPS (.SYS_CLK(SYS_CLK), .RST(RST),
	.FETCH(FETCH), .DATA(DATA), .IRQ_TAKEN(IRQ_TAKEN), .IRQ_VEC_USER(IRQ_VEC_USER),
	.SENSITIVE_MOVE(SENSITIVE_MOVE), .INT_ENABLE(INT_ENABLE), .INT_MASK(INT_MASK),
	.PRIV_MODE(PRIV_MODE), .VIOLATION_RESET(VIOLATION_RESET), .ERASE_REGS(ERASE_REGS),
	.EMU_BUS_GRANT(EMU_BUS_GRANT), .IRQ_ALLOW(IRQ_ALLOW), .INT_STATE(INT_STATE),
	.NEST_DEPTH(NEST_DEPTH));
